// [hdl/dfac_consts.vh]
// Constants for the channel 0 fast acquisition and clear-state control block.
// Assumes a Wishbone classic slave with 32-bit data; registers use the low byte, except the full-width history word.
`ifndef DFAC_CONSTS_VH
`define DFAC_CONSTS_VH

// Register indexes; byte address is four times the index
`define DFAC_IDX_QUAL          16'h2106
`define DFAC_IDX_CLEAR         16'h2107
`define DFAC_IDX_STATUS        16'h2108
`define DFAC_IDX_HISTORY       16'h2109
`define DFAC_IDX_MODE          16'h210a

// Qualifier register bits
`define DFAC_Q_FREERUN         0
`define DFAC_Q_HOLDOVER        1
`define DFAC_Q_FIRST           2
`define DFAC_Q_NOOUT           3

// Clear-state register bits
`define DFAC_C_AUTOSYNC        0
`define DFAC_C_HISTORY         1
`define DFAC_C_RSVD2           2
`define DFAC_C_FADONE          3
`define DFAC_C_AUTOMUTE        4

// Status register bits
`define DFAC_S_FADONE          0
`define DFAC_S_HISTAVAIL       1
`define DFAC_S_MUTED           2
`define DFAC_S_SYNCARMED       3

// Autosync mode field code for immediate sync
`define DFAC_SYNC_IMMEDIATE    2'b01

`define DFAC_RST_QUAL          8'h00
`define DFAC_RST_CLEAR         8'h00
`define DFAC_RST_MODE          8'h00

`endif

// [hdl/dfac_qualify.v]
// Fast acquisition qualifier: decides whether a fast acquisition may start.
// Assumes the mode-exit strobes are one-cycle pulses on clk_i.
`default_nettype none

module dfac_qualify (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [3:0] qual_i,
    input  wire       fa_done_i,
    input  wire       exit_holdover_i,
    input  wire       exit_freerun_i,
    input  wire       outputs_syncing_i,
    output reg        fa_start_o
);

`include "dfac_consts.vh"

    wire [3:0] eff_qual;
    wire       block_first;
    wire       block_noout;
    wire       want;

    // All-zero qualifiers act as all ones
    assign eff_qual    = (qual_i == 4'h0) ? 4'hf : qual_i;
    assign block_first = eff_qual[`DFAC_Q_FIRST] & fa_done_i;
    assign block_noout = eff_qual[`DFAC_Q_NOOUT] & outputs_syncing_i;
    assign want        = (exit_holdover_i & eff_qual[`DFAC_Q_HOLDOVER])
                       | (exit_freerun_i & eff_qual[`DFAC_Q_FREERUN]);

    always @(posedge clk_i) begin
        if (rst_i) begin
            fa_start_o <= 1'b0;
        end else begin
            fa_start_o <= want & ~block_first & ~block_noout;
        end
    end

endmodule

`default_nettype wire

// [hdl/dfac_ctrl.v]
// Channel 0 fast acquisition qualifiers and clear-state commands, Wishbone slave.
// Assumes classic Wishbone, 32-bit data, all inputs synchronous to clk_i.
`default_nettype none

module dfac_ctrl #(
    parameter TW_W = 32
) (
    input  wire            clk_i,
    input  wire            rst_i,
    input  wire            wb_cyc_i,
    input  wire            wb_stb_i,
    input  wire            wb_we_i,
    input  wire [31:0]     wb_adr_i,
    input  wire [3:0]      wb_sel_i,
    input  wire [31:0]     wb_dat_i,
    output reg  [31:0]     wb_dat_o,
    output reg             wb_ack_o,
    input  wire            exit_holdover_i,
    input  wire            exit_freerun_i,
    input  wire            outputs_syncing_i,
    input  wire            fa_complete_i,
    input  wire            in_holdover_i,
    input  wire            avg_valid_i,
    input  wire [TW_W-1:0] avg_word_i,
    input  wire [TW_W-1:0] freerun_word_i,
    input  wire            unmute_cond_i,
    input  wire            sync_cond_i,
    input  wire            analog_loop_ch0_locked_i,
    output wire            fa_start_o,
    output reg             mute_o,
    output reg             history_erase_o,
    output reg             sync_event_o,
    output reg  [TW_W-1:0] holdover_word_o
);

`include "dfac_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Bus decode

    reg  [7:0]      qual_r;
    reg  [1:0]      mode_r;
    reg             rsvd2_r;
    reg             fa_done_r;
    reg             hist_avail_r;
    reg  [TW_W-1:0] hist_word_r;
    reg             sync_armed_r;
    reg  [31:0]     rd_nxt;

    wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr_lane = req & wb_we_i & wb_sel_i[0];
    wire [29:0] idx     = wb_adr_i[31:2];

    function hit;
        input [29:0] a;
        input [15:0] target;
        begin
            hit = (a == {14'h0000, target});
        end
    endfunction

    wire wr_qual  = wr_lane & hit(idx, `DFAC_IDX_QUAL);
    wire wr_clear = wr_lane & hit(idx, `DFAC_IDX_CLEAR);
    wire wr_mode  = wr_lane & hit(idx, `DFAC_IDX_MODE);

    wire cmd_sync  = wr_clear & wb_dat_i[`DFAC_C_AUTOSYNC];
    wire cmd_hist  = wr_clear & wb_dat_i[`DFAC_C_HISTORY];
    wire cmd_fadn  = wr_clear & wb_dat_i[`DFAC_C_FADONE];
    wire cmd_mute  = wr_clear & wb_dat_i[`DFAC_C_AUTOMUTE];

    always @* begin
        rd_nxt = 32'h0000_0000;
        if (hit(idx, `DFAC_IDX_QUAL)) begin
            rd_nxt = {28'h0000000, qual_r[3:0]};
        end else if (hit(idx, `DFAC_IDX_CLEAR)) begin
            // Command bits always read zero
            rd_nxt = {29'h0000000, rsvd2_r, 2'b00};
        end else if (hit(idx, `DFAC_IDX_STATUS)) begin
            rd_nxt = {28'h0000000, sync_armed_r, mute_o, hist_avail_r, fa_done_r};
        end else if (hit(idx, `DFAC_IDX_HISTORY)) begin
            rd_nxt = hist_word_r[31:0];
        end else if (hit(idx, `DFAC_IDX_MODE)) begin
            rd_nxt = {30'h00000000, mode_r};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            qual_r   <= `DFAC_RST_QUAL;
            mode_r   <= 2'b00;
            rsvd2_r  <= 1'b0;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                wb_dat_o <= rd_nxt;
            end
            if (wr_qual) begin
                qual_r <= {4'h0, wb_dat_i[3:0]};
            end
            if (wr_mode) begin
                mode_r <= wb_dat_i[1:0];
            end
            if (wr_clear) begin
                rsvd2_r <= wb_dat_i[`DFAC_C_RSVD2];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Fast acquisition done flag and qualifier

    always @(posedge clk_i) begin
        if (rst_i) begin
            fa_done_r <= 1'b0;
        end else if (fa_complete_i) begin
            fa_done_r <= 1'b1;
        end else if (cmd_fadn) begin
            fa_done_r <= 1'b0;
        end
    end

    dfac_qualify u_qual (
        .clk_i             (clk_i),
        .rst_i             (rst_i),
        .qual_i            (qual_r[3:0]),
        .fa_done_i         (fa_done_r),
        .exit_holdover_i   (exit_holdover_i),
        .exit_freerun_i    (exit_freerun_i),
        .outputs_syncing_i (outputs_syncing_i),
        .fa_start_o        (fa_start_o)
    );

////////////////////////////////////////////////////////////////////////////////
// Tuning word history

    always @(posedge clk_i) begin
        if (rst_i) begin
            hist_avail_r    <= 1'b0;
            hist_word_r     <= {TW_W{1'b0}};
            history_erase_o <= 1'b0;
            holdover_word_o <= {TW_W{1'b0}};
        end else begin
            history_erase_o <= cmd_hist;
            if (avg_valid_i) begin
                hist_word_r  <= avg_word_i;
                hist_avail_r <= 1'b1;
            end else if (cmd_hist) begin
                hist_avail_r <= 1'b0;
            end
            if (in_holdover_i) begin
                holdover_word_o <= hist_avail_r ? hist_word_r : freerun_word_i;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Automute and autosync

    always @(posedge clk_i) begin
        if (rst_i) begin
            mute_o       <= 1'b1;
            sync_armed_r <= 1'b1;
            sync_event_o <= 1'b0;
        end else begin
            if (cmd_mute) begin
                mute_o <= 1'b1;
            end else if (unmute_cond_i) begin
                mute_o <= 1'b0;
            end
            sync_event_o <= 1'b0;
            if (cmd_sync && mode_r == `DFAC_SYNC_IMMEDIATE) begin
                sync_event_o <= analog_loop_ch0_locked_i;
                sync_armed_r <= ~analog_loop_ch0_locked_i;
            end else if (cmd_sync) begin
                sync_armed_r <= 1'b1;
            end else if (sync_armed_r && sync_cond_i) begin
                sync_event_o <= 1'b1;
                sync_armed_r <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// [verif/dfac_ctrl_assertions.sv]
// Checker for dfac_ctrl: bus answer timing, command side effects, qualified starts.
// Assumes it is bound into dfac_ctrl and sees only its ports.
`include "dfac_consts.vh"
`default_nettype none
module dfac_ctrl_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        exit_holdover_i,
    input wire logic        exit_freerun_i,
    input wire logic        fa_start_o,
    input wire logic        mute_o,
    input wire logic        history_erase_o,
    input wire logic        sync_event_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_cmd(b);
        s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == `DFAC_IDX_CLEAR * 4 && wb_dat_i[b]);
    endsequence
    a_ack_next: assert property (s_take |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_idle_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_start_cause: assert property (fa_start_o |-> $past(exit_holdover_i || exit_freerun_i))
        else $error("fast acquisition start without mode exit");
    a_mute_rearm: assert property (s_cmd(`DFAC_C_AUTOMUTE) |-> ##[1:2] mute_o)
        else $error("automute clear did not mute");
    a_erase_cmd: assert property (s_cmd(`DFAC_C_HISTORY) |-> ##[1:2] history_erase_o)
        else $error("history clear did not erase");
    a_erase_once: assert property (history_erase_o |=> !history_erase_o)
        else $error("erase pulse too long");
    a_sync_single: assert property (sync_event_o |=> !sync_event_o)
        else $error("sync event repeated");
endmodule
bind dfac_ctrl dfac_ctrl_chk u_chk (.*);
`default_nettype wire

// [verif/dfac_ctrl_tb.sv]
// Testbench for dfac_ctrl: Wishbone master tasks and loop strobes.
// Assumes TW_W of 32 and the checker bound separately.
`include "dfac_consts.vh"
`default_nettype none
module dfac_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [31:0] QA = `DFAC_IDX_QUAL * 4;
    localparam [31:0] CA = `DFAC_IDX_CLEAR * 4;
    localparam [31:0] SA = `DFAC_IDX_STATUS * 4;
    localparam [31:0] HA = `DFAC_IDX_HISTORY * 4;
    localparam [31:0] MA = `DFAC_IDX_MODE * 4;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, exit_holdover_i = 0;
    logic exit_freerun_i = 0, outputs_syncing_i = 0, fa_complete_i = 0, in_holdover_i = 0;
    logic avg_valid_i = 0, unmute_cond_i = 0, sync_cond_i = 0, analog_loop_ch0_locked_i = 0;
    logic [31:0] wb_adr_i = 0, wb_dat_i = 0, avg_word_i = 0, freerun_word_i = 32'h5a5a0f0f;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_o, holdover_word_o, rdat;
    logic wb_ack_o, fa_start_o, mute_o, history_erase_o, sync_event_o;
    int err_count = 0, n_compared = 0, n_sync = 0;
    dfac_ctrl u_dut (.*);
    initial forever #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (sync_event_o === 1'b1) n_sync++;
    task automatic chk(input [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic xfer(input w, input [31:0] a, d, input [3:0] s = 4'h1);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task automatic rd(input [31:0] a, e);
        xfer(0, a, 0);
        chk(e, rdat);
    endtask
    task automatic fa(input [3:0] q, input h, s, e);
        xfer(1, QA, {28'h0, q});
        outputs_syncing_i <= s;
        @(posedge clk_i);
        {exit_holdover_i, exit_freerun_i} <= {h, !h};
        @(posedge clk_i);
        {exit_holdover_i, exit_freerun_i} <= 2'b00;
        #1 chk({31'h0, e}, {31'h0, fa_start_o});
    endtask
    task automatic t_regs;
        chk(1, mute_o);
        rd(QA, 0);
        rd(CA, 0);
        rd(32'h0, 0);
        xfer(1, QA, 32'h5, 4'h0);
        rd(QA, 0);
    endtask
    task automatic t_fast;
        fa(0, 1, 0, 1);
        fa(0, 0, 0, 1);
        fa(1, 1, 0, 0);
        fa(2, 1, 0, 1);
        fa(2, 0, 0, 0);
        fa(1, 0, 0, 1);
        fa(4'hb, 1, 1, 0);
        fa(4'hb, 1, 0, 1);
        @(posedge clk_i);
        fa_complete_i <= 1;
        @(posedge clk_i);
        fa_complete_i <= 0;
        rd(SA, 32'hd);
        fa(7, 1, 0, 0);
        fa(3, 1, 0, 1);
        xfer(1, CA, 32'h8);
        rd(SA, 32'hc);
        rd(CA, 0);
        fa(7, 1, 0, 1);
    endtask
    task automatic t_hist;
        @(posedge clk_i);
        {avg_valid_i, avg_word_i, in_holdover_i} <= {1'b1, 32'h1234abcd, 1'b1};
        @(posedge clk_i);
        avg_valid_i <= 0;
        rd(SA, 32'he);
        xfer(1, CA, 32'h2);
        rd(SA, 32'hc);
        rd(HA, 32'h1234abcd);
        chk(freerun_word_i, holdover_word_o);
        {avg_valid_i, avg_word_i} <= {1'b1, 32'h0badf00d};
        @(posedge clk_i);
        avg_valid_i <= 0;
        rd(HA, 32'h0badf00d);
    endtask
    task automatic t_sync;
        @(posedge clk_i);
        sync_cond_i <= 1;
        repeat (6) @(posedge clk_i);
        sync_cond_i <= 0;
        chk(1, n_sync);
        xfer(1, MA, 1);
        analog_loop_ch0_locked_i <= 1;
        xfer(1, CA, 1);
        repeat (3) @(posedge clk_i);
        chk(2, n_sync);
        rd(CA, 0);
        analog_loop_ch0_locked_i <= 0;
        xfer(1, CA, 1);
        repeat (3) @(posedge clk_i);
        chk(2, n_sync);
        rd(SA, 32'he);
    endtask
    task automatic t_mute;
        unmute_cond_i <= 1;
        repeat (3) @(posedge clk_i);
        unmute_cond_i <= 0;
        #1 chk(0, mute_o);
        xfer(1, CA, 32'h10);
        repeat (2) @(posedge clk_i);
        #1 chk(1, mute_o);
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        t_regs;
        t_fast;
        t_hist;
        t_sync;
        t_mute;
        print_verdict;
    end
    initial begin
        #200000;
        err_count++;
        print_verdict;
    end
endmodule
`default_nettype wire
